// ### rtl/rtc_pkg.sv
// constants for the real-time modulo counter
package rtc_pkg;
  localparam logic [1:0] SRC_LPO = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [3:0] PS_OFF = 4'h0;
  localparam logic [3:0] PS_RESET = 4'h0;
  localparam logic [1:0] CLKS_RESET = 2'h0;
  localparam logic [7:0] MOD_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam int PRE_W = 18;
  localparam logic [PRE_W-1:0] PRE_ZERO = 18'h00000;
  localparam logic [PRE_W-1:0] PRE_ONE = 18'h00001;
  // status_control bit positions
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_CLKS_LSB = 5;
  localparam int SC_IE_BIT = 4;
  localparam int SC_PS_LSB = 0;
endpackage

// ### rtl/rtc_divider_lut.sv
`timescale 1ns/1ps
`default_nettype none
// prescaler divide-ratio lookup
module rtc_divider_lut (
  input wire logic [3:0] ps_i,
  input wire logic clks0_i,
  output logic [rtc_pkg::PRE_W-1:0] ratio_o
);
  always_comb begin
    ratio_o = rtc_pkg::PRE_ONE;
    if (!clks0_i) begin
      case (ps_i)
        4'h1: ratio_o = 18'h00008;
        4'h2: ratio_o = 18'h00020;
        4'h3: ratio_o = 18'h00040;
        4'h4: ratio_o = 18'h00080;
        4'h5: ratio_o = 18'h00100;
        4'h6: ratio_o = 18'h00200;
        4'h7: ratio_o = 18'h00400;
        4'h8: ratio_o = 18'h00001;
        4'h9: ratio_o = 18'h00002;
        4'hA: ratio_o = 18'h00004;
        4'hB: ratio_o = 18'h0000A;
        4'hC: ratio_o = 18'h00010;
        4'hD: ratio_o = 18'h00064;
        4'hE: ratio_o = 18'h001F4;
        4'hF: ratio_o = 18'h003E8;
        default: ratio_o = rtc_pkg::PRE_ONE;
      endcase
    end else begin
      case (ps_i)
        4'h1: ratio_o = 18'h00400;
        4'h2: ratio_o = 18'h00800;
        4'h3: ratio_o = 18'h01000;
        4'h4: ratio_o = 18'h02000;
        4'h5: ratio_o = 18'h04000;
        4'h6: ratio_o = 18'h08000;
        4'h7: ratio_o = 18'h10000;
        4'h8: ratio_o = 18'h003E8;
        4'h9: ratio_o = 18'h007D0;
        4'hA: ratio_o = 18'h01388;
        4'hB: ratio_o = 18'h02710;
        4'hC: ratio_o = 18'h04E20;
        4'hD: ratio_o = 18'h0C350;
        4'hE: ratio_o = 18'h186A0;
        4'hF: ratio_o = 18'h30D40;
        default: ratio_o = rtc_pkg::PRE_ONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rtl/rtc_modulo_counter.sv
`timescale 1ns/1ps
`default_nettype none
// real-time modulo counter with selectable source and prescaler
//
// Overview of operation
// - reset stops counter at zero, clears modulo, prescaler off
// - low-power oscillator is the default source after reset
// - prescale code zero keeps prescaler off; nonzero code starts it
// - source code 00 oscillator, 01 external, 1x internal reference
// - writing a different source code clears prescaler and counter
// - prescaler period follows prescale code and selected source
// - writing a different prescale code clears prescaler and counter
// - any 8-bit modulo value from 00 to FF accepted
// - counter steps once per prescaler period, wraps after modulo value
// - match flag sets on step from modulo value to zero
// - any modulo write clears prescaler and counter
// - interrupt request while flag and enable both set
// - software clears flag and request by writing one to flag bit
// - 8-bit count readable by software
// - writing zero to flag has no effect; reset clears control fields
// - modulo zero sets flag on every prescaler output period
// - count is read-only; writes do not affect it
// - divide ratios per code and low source-select bit
module rtc_modulo_counter (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic LOW_POWER_OSC_CLOCK_I,
  input wire logic EXTERNAL_REF_CLOCK_I,
  input wire logic INTERNAL_REF_CLOCK_I,
  input wire logic CTRL_WR_I,
  input wire logic [7:0] CTRL_WDATA_I,
  input wire logic MOD_WR_I,
  input wire logic [7:0] MOD_WDATA_I,
  output logic [7:0] STATUS_CONTROL_O,
  output logic [7:0] COUNT_VALUE_O,
  output logic [7:0] MODULO_VALUE_O,
  output logic MATCH_FLAG_O,
  output logic IRQ_O
);
  typedef enum logic {ST_STOPPED, ST_RUNNING} run_state_type;

  logic [1:0] clock_source_select_q;
  logic [3:0] prescale_select_q;
  logic match_irq_enable_q;
  logic match_flag_q;
  logic [7:0] modulo_value_q;
  logic [7:0] count_value_q;
  logic [rtc_pkg::PRE_W-1:0] pre_q;
  logic [rtc_pkg::PRE_W-1:0] ratio;
  logic [rtc_pkg::PRE_W-1:0] ratio_last;
  logic [2:0] src_pins;
  logic [2:0] src_prev_q;
  logic [2:0] src_rises;
  logic src_rise;
  logic pre_tick;
  logic clks_change;
  logic ps_change;
  logic restart;
  logic hold_clear;
  logic wrap;
  logic flag_clear_req;
  logic [7:0] status_word;
  run_state_type state_q;
  logic [1:0] new_clks;
  logic [3:0] new_ps;

  // prescale code zero means off; shared by the run state and the tick
  function automatic logic ps_on(input logic [3:0] ps);
    ps_on = (ps != rtc_pkg::PS_OFF);
  endfunction

  assign new_clks = CTRL_WDATA_I[rtc_pkg::SC_CLKS_LSB +: 2];
  assign new_ps = CTRL_WDATA_I[rtc_pkg::SC_PS_LSB +: 4];
  assign src_pins = {INTERNAL_REF_CLOCK_I, EXTERNAL_REF_CLOCK_I,
    LOW_POWER_OSC_CLOCK_I};

  // sources are sampled as synchronous levels, one history bit per pin;
  // a shared history would turn a source switch into a false edge
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      src_prev_q <= 3'h0;
    end else begin
      src_prev_q <= src_pins;
    end
  end
  assign src_rises = src_pins & ~src_prev_q;

  always_comb begin
    case (clock_source_select_q)
      rtc_pkg::SRC_LPO: src_rise = src_rises[0];
      rtc_pkg::SRC_EXT: src_rise = src_rises[1];
      default: src_rise = src_rises[2];
    endcase
  end

  rtc_divider_lut u_lut (
    .ps_i(prescale_select_q),
    .clks0_i(clock_source_select_q[0]),
    .ratio_o(ratio)
  );
  assign ratio_last = ratio - rtc_pkg::PRE_ONE;

  // a source edge in a restart cycle is dropped, so the first period
  // after a restart is always a full one
  assign clks_change = CTRL_WR_I && (new_clks != clock_source_select_q);
  assign ps_change = CTRL_WR_I && (new_ps != prescale_select_q);
  assign restart = MOD_WR_I | clks_change | ps_change;
  assign hold_clear = restart || (state_q != ST_RUNNING);

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clock_source_select_q <= rtc_pkg::CLKS_RESET;
    end else if (CTRL_WR_I) begin
      clock_source_select_q <= new_clks;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prescale_select_q <= rtc_pkg::PS_RESET;
    end else if (CTRL_WR_I) begin
      prescale_select_q <= new_ps;
    end
  end

  // enable-only writes touch no timing state
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      match_irq_enable_q <= 1'b0;
    end else if (CTRL_WR_I) begin
      match_irq_enable_q <= CTRL_WDATA_I[rtc_pkg::SC_IE_BIT];
    end
  end

  // any modulo write restarts, even one of the same value
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      modulo_value_q <= rtc_pkg::MOD_RESET;
    end else if (MOD_WR_I) begin
      modulo_value_q <= MOD_WDATA_I;
    end
  end

  // running starts one cycle after a nonzero code lands
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_STOPPED;
    end else begin
      case (state_q)
        ST_STOPPED: if (ps_on(prescale_select_q)) begin
          state_q <= ST_RUNNING;
        end
        ST_RUNNING: if (!ps_on(prescale_select_q)) begin
          state_q <= ST_STOPPED;
        end
        default: state_q <= ST_STOPPED;
      endcase
    end
  end

  // the state flop lags the code by a cycle, so the code is checked too
  assign pre_tick = (state_q == ST_RUNNING) && ps_on(prescale_select_q)
    && !restart && src_rise && (pre_q == ratio_last);

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_q <= rtc_pkg::PRE_ZERO;
    end else if (hold_clear) begin
      pre_q <= rtc_pkg::PRE_ZERO;
    end else if (pre_tick) begin
      pre_q <= rtc_pkg::PRE_ZERO;
    end else if (src_rise) begin
      pre_q <= pre_q + rtc_pkg::PRE_ONE;
    end
  end

  // with modulo zero every tick is a wrap
  assign wrap = pre_tick && (count_value_q == modulo_value_q);

  // no write port exists for the count
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count_value_q <= rtc_pkg::CNT_RESET;
    end else if (hold_clear) begin
      count_value_q <= rtc_pkg::CNT_RESET;
    end else if (wrap) begin
      count_value_q <= rtc_pkg::CNT_RESET;
    end else if (pre_tick) begin
      count_value_q <= count_value_q + 8'h01;
    end
  end

  assign flag_clear_req = CTRL_WR_I
    && CTRL_WDATA_I[rtc_pkg::SC_FLAG_BIT];

  // set beats clear so a wrap landing on the clearing write is not lost
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      match_flag_q <= 1'b0;
    end else if (wrap) begin
      match_flag_q <= 1'b1;
    end else if (flag_clear_req) begin
      match_flag_q <= 1'b0;
    end
  end

  always_comb begin
    status_word = 8'h00;
    status_word[rtc_pkg::SC_FLAG_BIT] = match_flag_q;
    status_word[rtc_pkg::SC_CLKS_LSB +: 2] = clock_source_select_q;
    status_word[rtc_pkg::SC_IE_BIT] = match_irq_enable_q;
    status_word[rtc_pkg::SC_PS_LSB +: 4] = prescale_select_q;
  end

  assign STATUS_CONTROL_O = status_word;
  assign COUNT_VALUE_O = count_value_q;
  assign MODULO_VALUE_O = modulo_value_q;
  assign MATCH_FLAG_O = match_flag_q;
  assign IRQ_O = match_flag_q & match_irq_enable_q;
endmodule
`default_nettype wire

// ### dv/rtc_modulo_counter_asserts.sv
// concurrent checks on the modulo counter ports
`timescale 1ns/1ps
`default_nettype none
module rtc_modulo_counter_asserts (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CTRL_WR_I,
  input wire logic [7:0] CTRL_WDATA_I,
  input wire logic MOD_WR_I,
  input wire logic [7:0] MOD_WDATA_I,
  input wire logic [7:0] STATUS_CONTROL_O,
  input wire logic [7:0] COUNT_VALUE_O,
  input wire logic [7:0] MODULO_VALUE_O,
  input wire logic MATCH_FLAG_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_wrap;
    $past(COUNT_VALUE_O) == MODULO_VALUE_O && COUNT_VALUE_O == 8'h00;
  endsequence
  a_irq_follows: assert property (
    IRQ_O == (MATCH_FLAG_O && STATUS_CONTROL_O[4])) else $error("irq");
  a_mod_restart: assert property (MOD_WR_I |=> COUNT_VALUE_O == 8'h00
    && MODULO_VALUE_O == $past(MOD_WDATA_I)) else $error("mod write");
  a_ps_restart: assert property (CTRL_WR_I &&
    CTRL_WDATA_I[3:0] != STATUS_CONTROL_O[3:0] |=> COUNT_VALUE_O == 8'h00)
    else $error("ps restart");
  a_src_restart: assert property (CTRL_WR_I &&
    CTRL_WDATA_I[6:5] != STATUS_CONTROL_O[6:5] |=> COUNT_VALUE_O == 8'h00)
    else $error("src restart");
  a_off_frozen: assert property (STATUS_CONTROL_O[3:0] == 4'h0 &&
    !MOD_WR_I && !CTRL_WR_I |=> $stable(COUNT_VALUE_O)
    && !$rose(MATCH_FLAG_O)) else $error("counting while off");
  a_flag_wrap: assert property ($rose(MATCH_FLAG_O) |-> s_wrap)
    else $error("flag without wrap");
  a_count_step: assert property ($changed(COUNT_VALUE_O) &&
    !$past(MOD_WR_I) && !$past(CTRL_WR_I) |->
    COUNT_VALUE_O == 8'($past(COUNT_VALUE_O) + 8'h01) ||
    ($past(COUNT_VALUE_O) == MODULO_VALUE_O && COUNT_VALUE_O == 8'h00))
    else $error("bad step");
  a_keep_flag: assert property (CTRL_WR_I && !CTRL_WDATA_I[7] &&
    MATCH_FLAG_O |=> MATCH_FLAG_O) else $error("flag lost");
  a_flag_clear: assert property (CTRL_WR_I && CTRL_WDATA_I[7] |=>
    (!MATCH_FLAG_O or s_wrap)) else $error("flag not cleared");
  a_fields_load: assert property (CTRL_WR_I |=>
    ($past(CTRL_WDATA_I) & 8'h7F) == (STATUS_CONTROL_O & 8'h7F))
    else $error("fields");
endmodule
bind rtc_modulo_counter rtc_modulo_counter_asserts chk (.CLK_SYS_I,
  .RST_N_I, .CTRL_WR_I, .CTRL_WDATA_I, .MOD_WR_I, .MOD_WDATA_I,
  .STATUS_CONTROL_O, .COUNT_VALUE_O, .MODULO_VALUE_O, .MATCH_FLAG_O, .IRQ_O);
`default_nettype wire

// ### dv/rtc_modulo_counter_tb_top.sv
// directed bench for the modulo counter
`timescale 1ns/1ps
`default_nettype none
module rtc_modulo_counter_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] src = 3'h0;
  logic cwr = 1'b0;
  logic mwr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] sc, cnt, modv;
  logic flag, irq;
  logic [1:0] s;
  logic [2:0] b;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int ratio [15] = '{8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100,
    500, 1000};
  always #5 clk = ~clk;
  rtc_modulo_counter dut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .LOW_POWER_OSC_CLOCK_I(src[0]), .EXTERNAL_REF_CLOCK_I(src[1]),
    .INTERNAL_REF_CLOCK_I(src[2]), .CTRL_WR_I(cwr), .CTRL_WDATA_I(wd),
    .MOD_WR_I(mwr), .MOD_WDATA_I(wd), .STATUS_CONTROL_O(sc),
    .COUNT_VALUE_O(cnt), .MODULO_VALUE_O(modv), .MATCH_FLAG_O(flag),
    .IRQ_O(irq));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic m, input logic [7:0] d);
    @(negedge clk);
    wd = d;
    cwr = !m;
    mwr = m;
    @(negedge clk);
    cwr = 1'b0;
    mwr = 1'b0;
    @(negedge clk);
  endtask
  // sources held low between pulses so no stray edge is seen
  task pulse(input logic [2:0] p, input int n);
    repeat (n) begin
      @(negedge clk);
      src = p;
      @(negedge clk);
      src = 3'h0;
    end
    repeat (3) @(negedge clk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      results;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk(sc, 8'h00);
    chk(modv, 8'h00);
    pulse(3'h1, 4);
    chk(cnt, 8'h00);
    wr(1'b0, 8'h08);
    wr(1'b1, 8'h03);
    pulse(3'h1, 3);
    chk(cnt, 8'h03);
    chk({7'h0, flag}, 8'h00);
    pulse(3'h1, 1);
    chk({cnt[6:0], flag}, 8'h01);
    wr(1'b0, 8'h18);
    chk({sc[6:0], irq}, 8'h31);
    wr(1'b0, 8'h98);
    chk({sc[6:0], irq}, 8'h30);
    pulse(3'h1, 2);
    wr(1'b0, 8'h19);
    chk(cnt, 8'h00);
    pulse(3'h1, 4);
    chk(cnt, 8'h02);
    wr(1'b1, 8'h03);
    chk(cnt, 8'h00);
    wr(1'b0, 8'h08);
    wr(1'b1, 8'hFF);
    pulse(3'h1, 255);
    chk(cnt, 8'hFF);
    wr(1'b1, 8'h00);
    @(negedge clk);
    wd = 8'h88;
    cwr = 1'b1;
    src = 3'h1;
    @(negedge clk);
    cwr = 1'b0;
    src = 3'h0;
    chk({7'h0, flag}, 8'h01);
    wr(1'b1, 8'h05);
    for (int i = 1; i <= 4; i++) begin
      s = 2'(i % 4);
      b = (s == 2'h0) ? 3'h1 : (s == 2'h1) ? 3'h2 : 3'h4;
      pulse(3'h1, 1);
      wr(1'b0, {1'b0, s, 5'h08});
      chk(cnt, 8'h00);
      pulse(~b, 1);
      pulse(b, s[0] ? 1000 : 1);
      chk(cnt, 8'h01);
    end
    wr(1'b1, 8'h00);
    for (int c = 1; c < 16; c++) begin
      wr(1'b0, 8'h80 | 8'(c));
      pulse(3'h1, ratio[c-1] - 1);
      chk({7'h0, flag}, 8'h00);
      pulse(3'h1, 1);
      chk({7'h0, flag}, 8'h01);
    end
    wr(1'b1, 8'h44);
    @(negedge clk);
    wd = 8'hB0;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    src = 3'h7;
    @(negedge clk);
    src = 3'h0;
    chk({cnt[6:0], flag}, 8'h00);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk(sc, 8'h00);
    chk(modv, 8'h00);
    results;
  end
endmodule
`default_nettype wire
